// ---- logic/fpe_pkg.sv ----
// Shared constants, types and register map of the flash program/erase/protect block
package fpe_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0]  FPE_OFF_CTRL     = 8'h00;
  localparam logic [7:0]  FPE_OFF_PROT     = 8'h04;
  localparam logic [7:0]  FPE_OFF_STAT     = 8'h08;

  // Field positions of flash_control
  localparam int          FPE_B_WS         = 0;
  localparam int          FPE_B_WIPE       = 1;
  localparam int          FPE_B_BULK       = 2;
  localparam int          FPE_B_HV         = 3;

  // Field positions of the status register
  localparam int          FPE_B_ST_LO      = 0;
  localparam int          FPE_B_REFUSED    = 3;
  localparam int          FPE_B_TESTHV     = 4;
  localparam int          FPE_B_BULKBLK    = 5;

  // Reset values
  localparam logic [3:0]  FPE_CTRL_RST     = 4'h0;
  localparam logic [31:0] FPE_RDATA_RST    = 32'h0000_0000;

  // Address map of the array
  localparam logic [15:0] FPE_FLASH_LO     = 16'hee00;
  localparam logic [15:0] FPE_PBYTE_ADDR   = 16'hffbe;
  localparam logic [7:0]  FPE_PROT_OPEN    = 8'hff;
  localparam logic [1:0]  FPE_PROT_TOP     = 2'h3;
  localparam logic [5:0]  FPE_PROT_LOW     = 6'h00;
  localparam logic [5:0]  FPE_PAGE_MASK    = 6'h3f;
  localparam logic [4:0]  FPE_ROW_MASK     = 5'h1f;

  // Synchroniser depth
  localparam int          FPE_SYNC_STAGES  = 2;

  // Control register image
  typedef struct packed {
    logic hv;
    logic bulk;
    logic wipe;
    logic ws;
  } fpe_ctrl_s;

  // Processor write toward the flash array
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } fpe_fw_s;

  // Sequence tracker states
  typedef enum logic [2:0] {
    FPE_IDLE    = 3'b000,
    FPE_ARMED   = 3'b001,
    FPE_CHECKED = 3'b010,
    FPE_LATCHED = 3'b011,
    FPE_HV      = 3'b100
  } fpe_state_e;

endpackage

// ---- logic/fpe_sync.sv ----
// Two-flop level synchroniser with clock enable
`timescale 1ns/100ps
`default_nettype none
module fpe_sync
  import fpe_pkg::*;
(
  input  wire logic CLK,     // Bus clock
  input  wire logic RESET_N, // Synchronous reset, active low
  input  wire logic CE,      // Clock enable
  input  wire logic D,       // Asynchronous level
  output var  logic Q        // Synchronised level
);

  logic [FPE_SYNC_STAGES-1:0] stage_ff;

  // First stage feeds only the second
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      stage_ff <= '0;
    end else if (CE) begin
      stage_ff <= {stage_ff[FPE_SYNC_STAGES-2:0], D};
    end
  end

  assign Q = stage_ff[FPE_SYNC_STAGES-1];

endmodule
`default_nettype wire

// ---- logic/fpe_prot.sv ----
// Protect start address and hit check for one target address
`timescale 1ns/100ps
`default_nettype none
module fpe_prot
  import fpe_pkg::*;
(
  input  wire logic [7:0]  PBITS,   // protect_start_bits
  input  wire logic [15:0] TARGET,  // Page or row base being checked
  output var  logic [15:0] START,   // Protect start address
  output var  logic        OPEN,    // Whole array unprotected
  output var  logic        HIT      // Target lies in protected range
);

  assign START = {FPE_PROT_TOP, PBITS, FPE_PROT_LOW};
  assign OPEN  = (PBITS == FPE_PROT_OPEN);
  // range up to the top; low values start below the array so cover all of it
  assign HIT   = !OPEN && (TARGET >= START);

endmodule
`default_nettype wire

// ---- logic/fpe_top.sv ----
// Flash program / erase sequencer with block protection, APB register slave
//
// Summary of operation
// - Wipe-select and write-select never both one; such writes are refused.
// - Bulk-wipe-select one turns the erase into a whole-array erase.
// - Page erase clears 64 aligned bytes chosen by the latching write address.
// - Bulk erase blocked when protect byte is not all ones, unless test high voltage is detected.
// - Programming works on aligned 32-byte rows; all bytes in one row.
// - Write-select enables latching of address and data for programming.
// - High voltage refused when target lies in protected range.
// - Protected range runs from start address to the last flash address.
// - Start address is protect bits at 13..6, top ones, low zeros.
// - Protect values up to the lowest page value protect whole array.
// - Protect value all ones leaves array open.
// - Non-open protect byte forbids changing itself and protected block.
// - Non-open protect byte may change only with test high voltage detected.
// - Erasing the top vector page also erases the trim bytes.
// - High voltage set only with a select bit and prior steps done.
// - Erased bits read one, programmed bits read zero.
`timescale 1ns/100ps
`default_nettype none
module fpe_top
  import fpe_pkg::*;
(
  input  wire logic        CLK,       // Bus clock, 40 MHz
  input  wire logic        RESET_N,   // Synchronous reset, active low
  input  wire logic        CE,        // Clock enable, freezes all state when low
  input  wire logic        PSEL,      // APB select
  input  wire logic        PENABLE,   // APB enable
  input  wire logic        PWRITE,    // APB direction
  input  wire logic [7:0]  PADDR,     // APB byte address
  input  wire logic [31:0] PWDATA,    // APB write data
  output var  logic [31:0] PRDATA,    // APB read data
  output var  logic        PREADY,    // APB ready
  output var  logic        PSLVERR,   // APB error
  input  wire logic        FW_VALID,  // Processor write to flash space
  input  wire logic [15:0] FW_ADDR,   // Its address
  input  wire logic [7:0]  FW_DATA,   // Its data
  input  wire logic [7:0]  PROT_BITS, // protect_start_bits from the array
  input  wire logic        TEST_HV,   // test_high_voltage detector pin
  output var  logic        ARR_HV,    // Charge pump high voltage on
  output var  logic        ARR_ERASE, // Erase pulse level to the array
  output var  logic        ARR_BULK,  // Erase covers whole array
  output var  logic        ARR_PROG,  // Program mode level
  output var  logic        ARR_WR,    // Program one byte, one-cycle pulse
  output var  logic [15:0] ARR_ADDR,  // Page base, row byte address
  output var  logic [7:0]  ARR_DATA   // Byte to program
);

  fpe_ctrl_s   ctrl_ff, nxt_ctrl;
  fpe_state_e  state_ff, nxt_state;
  fpe_fw_s     fw;
  logic [15:0] lat_addr_ff, nxt_lat_addr;
  logic        pready_ff, pslverr_ff, refused_ff, nxt_refused;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        arr_hv_ff, arr_erase_ff, arr_bulk_ff, arr_prog_ff, arr_wr_ff;
  logic [15:0] arr_addr_ff, nxt_arr_addr;
  logic [7:0]  arr_data_ff;
  logic        test_hv_s;

  assign fw = '{valid: FW_VALID, addr: FW_ADDR, data: FW_DATA};

  // Pin from outside the clock domain
  fpe_sync u_sync (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .CE      (CE),
    .D       (TEST_HV),
    .Q       (test_hv_s)
  );

  // APB phase decode; one wait state keeps outputs registered
  wire acc_phase = PSEL && PENABLE && !pready_ff;
  wire commit    = PSEL && PENABLE && pready_ff;
  wire hit_ctrl  = (PADDR == FPE_OFF_CTRL);
  wire hit_prot  = (PADDR == FPE_OFF_PROT);
  wire hit_stat  = (PADDR == FPE_OFF_STAT);
  wire unmapped  = !(hit_ctrl || hit_prot || hit_stat);
  wire wr_ctrl   = commit && PWRITE && hit_ctrl;
  wire wr_stat   = commit && PWRITE && hit_stat;
  wire rd_prot   = commit && !PWRITE && hit_prot;

  // Write data viewed as a control image
  wire fpe_ctrl_s w_ctrl = PWDATA[3:0];
  wire both_sel  = w_ctrl.ws && w_ctrl.wipe;
  // Protect byte is read-only here; it changes only through a program or erase sequence
  wire ro_write  = PWRITE && hit_prot;
  wire bus_err   = unmapped || ro_write || (PWRITE && hit_ctrl && both_sel);

  // Page or row base of the latched target, for the range check
  wire [15:0] page_base = {lat_addr_ff[15:6], ~FPE_PAGE_MASK & 6'h00};
  wire [15:0] row_base  = {lat_addr_ff[15:5], ~FPE_ROW_MASK & 5'h00};
  wire [15:0] tgt_base  = ctrl_ff.wipe ? page_base : row_base;

  logic [15:0] prot_start;
  logic        prot_open, prot_hit;

  // Protect decode of the latched target
  fpe_prot u_prot (
    .PBITS  (PROT_BITS),
    .TARGET (tgt_base),
    .START  (prot_start),
    .OPEN   (prot_open),
    .HIT    (prot_hit)
  );

  // target covers the protect byte itself
  wire covers_pbyte = ctrl_ff.wipe ? (lat_addr_ff[15:6] == FPE_PBYTE_ADDR[15:6])
                                   : (lat_addr_ff[15:5] == FPE_PBYTE_ADDR[15:5]);
  // bulk blocked unless open; test voltage admits the failed-security wipe
  wire bulk_blk  = !prot_open && !test_hv_s;
  // range block, test voltage lets the protect byte page or row through
  wire range_blk = prot_hit && !(test_hv_s && covers_pbyte);
  wire new_bulk  = w_ctrl.wipe && w_ctrl.bulk;
  wire hv_block  = new_bulk ? bulk_blk : range_blk;
  // high voltage needs a select and the latching step done
  wire hv_ok     = (state_ff == FPE_LATCHED) && (w_ctrl.ws || w_ctrl.wipe) && !hv_block;
  // Only a rising request can be refused; a held high voltage is never re-checked
  wire hv_req    = wr_ctrl && !both_sel && w_ctrl.hv && !ctrl_ff.hv;

  // Control register next value
  always_comb begin
    nxt_ctrl = ctrl_ff;
    // refuse the whole write if both selects asked
    if (wr_ctrl && !both_sel) begin
      nxt_ctrl.ws   = w_ctrl.ws;
      nxt_ctrl.wipe = w_ctrl.wipe;
      nxt_ctrl.bulk = w_ctrl.bulk;
      nxt_ctrl.hv   = w_ctrl.hv && (ctrl_ff.hv || hv_ok);
    end
  end

  // Refused-HV flag: hardware set wins over software clear
  always_comb begin
    nxt_refused = refused_ff;
    if (wr_stat && PWDATA[FPE_B_REFUSED]) begin
      nxt_refused = 1'b0;
    end
    if (hv_req && !hv_ok) begin
      nxt_refused = 1'b1;
    end
  end

  // Flash writes that count as a latching write
  wire fw_in_flash = fw.valid && (fw.addr >= FPE_FLASH_LO);
  wire any_sel     = nxt_ctrl.ws || nxt_ctrl.wipe;
  wire all_clear   = !any_sel && !nxt_ctrl.hv;

  always_comb begin
    nxt_state    = state_ff;
    nxt_lat_addr = lat_addr_ff;
    unique case (state_ff)
      FPE_IDLE: begin
        if (any_sel) begin
          nxt_state = FPE_ARMED;
        end
      end
      // protect read must precede the latching write
      FPE_ARMED: begin
        if (rd_prot) begin
          nxt_state = FPE_CHECKED;
        end
      end
      // latch address after a select; protect byte address accepted too
      FPE_CHECKED: begin
        if (fw_in_flash) begin
          nxt_state    = FPE_LATCHED;
          nxt_lat_addr = fw.addr;
        end
      end
      FPE_LATCHED: begin
        if (nxt_ctrl.hv) begin
          nxt_state = FPE_HV;
        end
      end
      FPE_HV: begin
        if (!nxt_ctrl.hv) begin
          nxt_state = FPE_ARMED;
        end
      end
      default: begin
        nxt_state = FPE_IDLE;
      end
    endcase
    // all bits clear ends any sequence
    if (all_clear) begin
      nxt_state = FPE_IDLE;
    end
  end

  // program write must stay in the latched row
  wire same_row  = (fw.addr[15:5] == lat_addr_ff[15:5]);
  // out-of-row writes ignored under high voltage
  wire prog_wr   = (state_ff == FPE_HV) && ctrl_ff.hv && ctrl_ff.ws &&
                   fw_in_flash && same_row;
  wire erase_on  = (state_ff == FPE_HV) && ctrl_ff.hv && ctrl_ff.wipe;
  wire prog_on   = (state_ff == FPE_HV) && ctrl_ff.hv && ctrl_ff.ws;

  // page base address; the vector page holds the trim bytes too
  always_comb begin
    nxt_arr_addr = arr_addr_ff;
    if (prog_wr) begin
      nxt_arr_addr = fw.addr;
    end else if (erase_on) begin
      nxt_arr_addr = ctrl_ff.bulk ? FPE_FLASH_LO : page_base;
    end
  end

  // Read mux, captured with the wait state
  wire [31:0] stat_word = {26'h0, bulk_blk, test_hv_s, refused_ff, state_ff};
  always_comb begin
    nxt_prdata = FPE_RDATA_RST;
    if (hit_ctrl) begin
      nxt_prdata = {28'h0, ctrl_ff};
    end else if (hit_prot) begin
      nxt_prdata = {24'h0, PROT_BITS};
    end else if (hit_stat) begin
      nxt_prdata = stat_word;
    end
  end

  // APB handshake registers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= FPE_RDATA_RST;
    end else if (CE) begin
      pready_ff  <= acc_phase;
      pslverr_ff <= acc_phase && bus_err;
      if (acc_phase) begin
        prdata_ff <= PWRITE ? FPE_RDATA_RST : nxt_prdata;
      end
    end
  end

  // Control, status and sequence state
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl_ff     <= FPE_CTRL_RST;
      state_ff    <= FPE_IDLE;
      lat_addr_ff <= FPE_FLASH_LO;
      refused_ff  <= 1'b0;
    end else if (CE) begin
      ctrl_ff     <= nxt_ctrl;
      state_ff    <= nxt_state;
      lat_addr_ff <= nxt_lat_addr;
      refused_ff  <= nxt_refused;
    end
  end

  // Array drive; erase drives cells to one, programming pulls bits to zero
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      arr_hv_ff    <= 1'b0;
      arr_erase_ff <= 1'b0;
      arr_bulk_ff  <= 1'b0;
      arr_prog_ff  <= 1'b0;
      arr_wr_ff    <= 1'b0;
      arr_addr_ff  <= FPE_FLASH_LO;
      arr_data_ff  <= 8'h00;
    end else if (CE) begin
      arr_hv_ff    <= ctrl_ff.hv;
      arr_erase_ff <= erase_on;
      arr_bulk_ff  <= erase_on && ctrl_ff.bulk;
      arr_prog_ff  <= prog_on;
      arr_wr_ff    <= prog_wr;
      arr_addr_ff  <= nxt_arr_addr;
      if (prog_wr) begin
        arr_data_ff <= fw.data;
      end
    end
  end

  assign PRDATA    = prdata_ff;
  assign PREADY    = pready_ff;
  assign PSLVERR   = pslverr_ff;
  assign ARR_HV    = arr_hv_ff;
  assign ARR_ERASE = arr_erase_ff;
  assign ARR_BULK  = arr_bulk_ff;
  assign ARR_PROG  = arr_prog_ff;
  assign ARR_WR    = arr_wr_ff;
  assign ARR_ADDR  = arr_addr_ff;
  assign ARR_DATA  = arr_data_ff;

endmodule
`default_nettype wire

// ---- dv/fpe_chk_assertions.sv ----
// Port-level assertion checker for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module fpe_chk
  import fpe_pkg::*;
(
  input wire logic        CLK,       // Clock
  input wire logic        RESET_N,   // Reset, low
  input wire logic        PSEL,      // Select
  input wire logic        PENABLE,   // Enable
  input wire logic        PREADY,    // Ready
  input wire logic        PSLVERR,   // Error
  input wire logic        FW_VALID,  // Flash write
  input wire logic [15:0] FW_ADDR,   // Its address
  input wire logic [7:0]  FW_DATA,   // Its data
  input wire logic [7:0]  PROT_BITS, // Protect bits
  input wire logic        TEST_HV,   // Test voltage
  input wire logic        ARR_HV,    // Pump on
  input wire logic        ARR_ERASE, // Erasing
  input wire logic        ARR_BULK,  // Whole array
  input wire logic        ARR_PROG,  // Program mode
  input wire logic        ARR_WR,    // Byte pulse
  input wire logic [15:0] ARR_ADDR,  // Address
  input wire logic [7:0]  ARR_DATA   // Data
);
  // Loose on test voltage: the bench holds it steady around sequences
  wire        open_w  = (PROT_BITS == FPE_PROT_OPEN) || TEST_HV;
  wire [15:0] start_w = {FPE_PROT_TOP, PROT_BITS, FPE_PROT_LOW};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  chk_apb_wait: assert property ($rose(PENABLE) && PSEL |=> PREADY)
    else $error("ready late");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  chk_mode_excl: assert property (!(ARR_ERASE && ARR_PROG))
    else $error("erase and program together");
  chk_wr_follow: assert property (ARR_WR |-> $past(FW_VALID) &&
    ARR_ADDR == $past(FW_ADDR) && ARR_DATA == $past(FW_DATA) && !$past(ARR_WR))
    else $error("byte pulse without cause");
  chk_wr_prot: assert property (ARR_WR |-> ARR_HV && (open_w || ARR_ADDR < start_w))
    else $error("program in protected range");
  chk_page_prot: assert property (ARR_ERASE && !ARR_BULK |->
    ARR_ADDR[5:0] == 6'h00 && (open_w || ARR_ADDR < start_w))
    else $error("bad page erase");
  chk_bulk_block: assert property (ARR_BULK |-> open_w)
    else $error("bulk erase while protected");
  cov_prog: cover property (ARR_WR);
  cov_bulk: cover property (ARR_ERASE && ARR_BULK);
  cov_page: cover property (ARR_ERASE && !ARR_BULK);
endmodule
bind fpe_top fpe_chk fpe_chk_i (.*);
`default_nettype wire

// ---- dv/fpe_array_model.sv ----
// Behavioural flash array at the far side of the sequencer
`timescale 1ns/100ps
`default_nettype none
module fpe_array_model
(
  input  wire logic        clk,       // Bus clock
  input  wire logic [7:0]  pset,      // Stored protect byte
  input  wire logic        arr_wr,    // Byte pulse
  input  wire logic        arr_erase, // Erase level
  input  wire logic        arr_bulk,  // Whole array
  input  wire logic [15:0] arr_addr,  // Address
  input  wire logic [7:0]  arr_data,  // Data
  output var  logic [7:0]  prot_bits, // Protect byte out
  output var  logic [15:0] rec_addr,  // Last address hit
  output var  logic [7:0]  rec_data,  // Its content
  output var  logic        rec_bulk,  // Last erase bulk
  output var  logic [7:0]  hits       // Operations seen
);
  logic       erase_q = 1'b0;
  logic [7:0] hit_cnt = 8'h00;
  assign prot_bits = pset;
  assign hits      = hit_cnt;
  always @(posedge clk) begin
    erase_q <= arr_erase;
    if (arr_wr) begin
      rec_addr <= arr_addr;
      rec_data <= arr_data;
      hit_cnt  <= hit_cnt + 8'h01;
    end else if (arr_erase && !erase_q) begin
      rec_addr <= arr_addr;
      rec_data <= 8'hff;
      rec_bulk <= arr_bulk;
      hit_cnt  <= hit_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- dv/fpe_top_bench.sv ----
// Self-checking bench for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module fpe_top_bench
  import fpe_pkg::*;
;
  logic        CLK, RESET_N, PSEL, PENABLE, PWRITE, FW_VALID, TEST_HV, ce, e, thv, ok;
  logic [7:0]  PADDR, FW_DATA, pset, pb, h0;
  logic [15:0] FW_ADDR, ad;
  logic [31:0] PWDATA, r;
  logic [2:0]  sel;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, ARR_HV, ARR_ERASE, ARR_BULK, ARR_PROG, ARR_WR, rec_bulk;
  wire  [15:0] ARR_ADDR, rec_addr;
  wire  [7:0]  ARR_DATA, PROT_BITS, rec_data, hits;
  int          err_total, check_count;
  // Cases: test voltage, protect byte, selects, address, HV allowed
  logic [28:0] tb [12] = '{
    {1'b0, 8'hff, 3'h1, 16'hf000, 1'b1},
    {1'b0, 8'hb9, 3'h1, 16'hf000, 1'b0},
    {1'b0, 8'hb9, 3'h1, 16'hee00, 1'b1},
    {1'b0, 8'hb8, 3'h1, 16'hee00, 1'b0},
    {1'b0, 8'h00, 3'h2, 16'hf000, 1'b0},
    {1'b0, 8'hfe, 3'h2, 16'hff45, 1'b1},
    {1'b0, 8'hfe, 3'h2, 16'hffbe, 1'b0},
    {1'b0, 8'hb9, 3'h6, 16'hee00, 1'b0},
    {1'b0, 8'hff, 3'h6, 16'hf123, 1'b1},
    {1'b1, 8'hb9, 3'h6, 16'hffbe, 1'b1},
    {1'b1, 8'hfe, 3'h2, 16'hffbe, 1'b1},
    {1'b0, 8'hff, 3'h2, 16'hffc1, 1'b1}
  };

  fpe_top fpe_top_i (.CLK(CLK), .RESET_N(RESET_N), .CE(ce), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .FW_VALID(FW_VALID), .FW_ADDR(FW_ADDR),
    .FW_DATA(FW_DATA), .PROT_BITS(PROT_BITS), .TEST_HV(TEST_HV), .ARR_HV(ARR_HV),
    .ARR_ERASE(ARR_ERASE), .ARR_BULK(ARR_BULK), .ARR_PROG(ARR_PROG), .ARR_WR(ARR_WR),
    .ARR_ADDR(ARR_ADDR), .ARR_DATA(ARR_DATA));
  fpe_array_model fpe_array_model_i (.clk(CLK), .pset(pset), .arr_wr(ARR_WR),
    .arr_erase(ARR_ERASE), .arr_bulk(ARR_BULK), .arr_addr(ARR_ADDR), .arr_data(ARR_DATA),
    .prot_bits(PROT_BITS), .rec_addr(rec_addr), .rec_data(rec_data), .rec_bulk(rec_bulk),
    .hits(hits));

  task close_out;
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // One APB transfer; request held until ready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      err_total++;
      close_out;
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Processor write into flash space, one cycle
  task fw(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK);
    FW_VALID <= 1'b1;
    FW_ADDR <= a;
    FW_DATA <= d;
    @(posedge CLK);
    FW_VALID <= 1'b0;
  endtask

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // Reset, register map checks, then every sequence case
  initial begin
    {RESET_N, PSEL, PENABLE, PWRITE, FW_VALID, TEST_HV} = 6'h00;
    {PADDR, FW_DATA, PWDATA, FW_ADDR} = 64'h0;
    pset = 8'hff;
    ce = 1'b1;
    err_total = 0;
    check_count = 0;
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    apb(1'b0, FPE_OFF_CTRL, 32'h0); chk(r, 32'h0);
    apb(1'b1, FPE_OFF_CTRL, 32'h3); chk(e, 1'b1);
    apb(1'b0, FPE_OFF_CTRL, 32'h0); chk(r, 32'h0);
    apb(1'b1, FPE_OFF_PROT, 32'h0); chk(e, 1'b1);
    apb(1'b0, 8'h0c, 32'h0); chk({e, r[30:0]}, 32'h80000000);
    for (int i = 0; i < 12; i++) begin
      {thv, pb, sel, ad, ok} = tb[i];
      TEST_HV <= thv;
      pset <= pb;
      repeat (4) @(posedge CLK);
      apb(1'b1, FPE_OFF_CTRL, {29'h0, sel});
      apb(1'b0, FPE_OFF_PROT, 32'h0); chk(r, pb);
      // Frozen clock enable must drop a latching write
      ce <= 1'b0;
      fw(ad, 8'h11);
      ce <= 1'b1;
      apb(1'b0, FPE_OFF_STAT, 32'h0); chk(r[2:0], 3'h2);
      fw(ad, 8'h11);
      apb(1'b0, FPE_OFF_STAT, 32'h0); chk(r[2:0], 3'h3);
      h0 = hits;
      apb(1'b1, FPE_OFF_CTRL, {28'h0, 1'b1, sel});
      apb(1'b0, FPE_OFF_CTRL, 32'h0); chk(r[3], ok);
      apb(1'b0, FPE_OFF_STAT, 32'h0); chk(r[3], !ok);
      if (sel == 3'h1) begin
        fw(ad + 16'h5, 8'h5a);
        fw(ad + 16'h25, 8'h77);
      end
      repeat (3) @(posedge CLK);
      chk(hits - h0, ok);
      chk({ARR_HV, ARR_BULK, ARR_ERASE, ARR_PROG}, {ok, {3{ok}} & sel});
      if (ok) begin
        chk(rec_addr, sel == 3'h1 ? ad + 16'h5 : sel[2] ? FPE_FLASH_LO : ad & 16'hffc0);
        chk(rec_data, sel == 3'h1 ? 8'h5a : 8'hff);
        chk(rec_bulk & sel[1], sel[2]);
      end
      apb(1'b1, FPE_OFF_CTRL, 32'h8); chk(e, 1'b0);
      apb(1'b1, FPE_OFF_CTRL, 32'h0);
      apb(1'b1, FPE_OFF_STAT, 32'h8);
      apb(1'b0, FPE_OFF_STAT, 32'h0); chk(r[3:0], 4'h0);
      chk({ARR_HV, ARR_ERASE, ARR_PROG}, 3'h0);
    end
    close_out;
  end
endmodule
`default_nettype wire
